/* debug_watch_pkg.sv */
/*
  Package for the debug breakpoint and watchpoint unit: register indices,
  field positions, reset values, cause codes and carrier structs.
  Assumes register numbers are word indices; byte address is four times the index.
*/
package debug_watch_pkg;

  localparam int unsigned units_count          = 4;
  localparam int unsigned threads_count        = 8;
  localparam int unsigned scratch_count        = 8;

  localparam logic [7:0]  idx_event_data       = 8'h16;
  localparam logic [7:0]  idx_stop_mask        = 8'h18;
  localparam logic [7:0]  idx_scratch_base     = 8'h20;
  localparam logic [7:0]  idx_code_addr_base   = 8'h30;
  localparam logic [7:0]  idx_code_ctrl_base   = 8'h40;
  localparam logic [7:0]  idx_data_first_base  = 8'h50;
  localparam logic [7:0]  idx_data_second_base = 8'h60;
  localparam logic [7:0]  idx_data_ctrl_base   = 8'h70;
  localparam logic [7:0]  idx_res_mask_base    = 8'h80;
  localparam logic [7:0]  idx_res_value_base   = 8'h90;
  localparam logic [7:0]  idx_res_ctrl_base    = 8'h9c;
  localparam logic [7:0]  idx_event_cause      = 8'ha0;
  localparam logic [7:0]  idx_irq_status       = 8'ha1;
  localparam logic [7:0]  idx_irq_mask         = 8'ha2;

  localparam int unsigned watch_enable_bit        = 0;
  localparam int unsigned condition_combine_bit   = 1;
  localparam int unsigned trigger_on_load_bit     = 2;
  localparam int unsigned per_thread_enable_lo    = 16;
  localparam int unsigned per_thread_enable_hi    = 23;

  localparam logic [31:0] code_ctrl_write_mask = 32'h00ff_0003;
  localparam logic [31:0] data_ctrl_write_mask = 32'h00ff_0007;
  localparam logic [31:0] res_ctrl_write_mask  = 32'h00ff_0003;
  localparam logic [31:0] ctrl_reset_value     = 32'h0000_0000;
  localparam logic [31:0] word_reset_value     = 32'h0000_0000;
  localparam logic [7:0]  stop_mask_reset      = 8'h00;

  localparam logic [2:0]  cause_none           = 3'h0;
  localparam logic [2:0]  cause_code_break     = 3'h3;
  localparam logic [2:0]  cause_data_watch     = 3'h4;
  localparam logic [2:0]  cause_res_watch      = 3'h5;

  localparam int unsigned irq_code_pos         = 0;
  localparam int unsigned irq_data_pos         = 1;
  localparam int unsigned irq_res_pos          = 2;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] pc;
  } fetch_type;

  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic [2:0]  thread;
    logic [31:0] address;
  } memory_op_type;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] resource_id;
  } resource_op_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  address;
    logic [31:0] write_data;
  } reg_request_type;

  typedef struct packed {
    logic        write;
    logic [2:0]  index;
    logic [31:0] write_data;
  } scratch_request_type;

endpackage

/* debug_breakpoint_watch_unit.sv */
/*
  Debug breakpoint and watchpoint unit: four code breakpoints, four data
  watchpoints, four resource watchpoints, stop mask, event data, scratch words.
  Assumes pipeline inputs are synchronous to clock and valid for one cycle each.
*/
// Summary of operation
// - Data watch hit loads event data with the memory effective address.
// - Resource watch hit loads event data with the resource identifier.
// - Eight-bit stop mask holds set threads stopped after debug return.
// - Eight shared scratch words, reachable from debug port and tile config port.
// - Four code breakpoints with 32-bit address raise a debug interrupt on match.
// - Bits 23:16 of each control enable the unit per thread.
// - Code condition bit: clear breaks on equal, set breaks on not equal.
// - Control bit 0 enables the unit; all controls reset to zero.
// - Each data watch has first and second 32-bit address registers.
// - Data control bit 2 makes the watch fire on loads meeting its condition.
// - Data combine bit: clear needs A and B, set needs A or B.
// - Each resource watch has 32-bit mask and value registers.
// - Resource condition bit: clear uses condition A, set uses the inverse of condition A.
// - Taken event records cause 3 code, 4 data, 5 resource.
`timescale 1ns/10ps
module debug_breakpoint_watch_unit
  import debug_watch_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire fetch_type           fetch,
  input  wire memory_op_type       memory_op,
  input  wire resource_op_type     resource_op,
  input  wire logic                debug_return,
  input  wire reg_request_type     reg_request,
  input  wire scratch_request_type scratch_request,
  output logic [31:0]              read_data,
  output logic [31:0]              scratch_read_data,
  output logic                     debug_interrupt,
  output logic [2:0]               debug_thread,
  output logic [7:0]               thread_stopped,
  output logic                     irq
);

  typedef struct packed {
    logic [31:0]                     debug_event_data;
    logic [7:0]                      thread_stop_mask;
    logic [7:0]                      thread_stopped;
    logic [scratch_count-1:0][31:0]  debugger_scratch_words;
    logic [units_count-1:0][31:0]    code_break_address;
    logic [units_count-1:0][31:0]    code_break_control;
    logic [units_count-1:0][31:0]    data_watch_first_address;
    logic [units_count-1:0][31:0]    data_watch_second_address;
    logic [units_count-1:0][31:0]    data_watch_control;
    logic [units_count-1:0][31:0]    resource_watch_mask;
    logic [units_count-1:0][31:0]    resource_watch_value;
    logic [units_count-1:0][31:0]    resource_watch_control;
    logic [2:0]                      event_cause;
    logic [2:0]                      irq_status;
    logic [2:0]                      irq_mask;
    logic [31:0]                     read_data;
    logic [31:0]                     scratch_read_data;
    logic                            debug_interrupt;
    logic [2:0]                      debug_thread;
    logic                            irq;
  } state_type;

  state_type state;
  state_type next_state;

  function automatic logic thread_allowed(input logic [31:0] control,
                                          input logic [2:0]  thread);
    logic [7:0] field;
    field = control[per_thread_enable_hi:per_thread_enable_lo];
    return control[watch_enable_bit] && field[thread];
  endfunction

  function automatic logic in_block(input logic [7:0] address,
                                    input logic [7:0] base);
    return address[7:2] == base[7:2];
  endfunction

  logic [units_count-1:0] code_hit;
  logic [units_count-1:0] data_hit;
  logic [units_count-1:0] res_hit;

  genvar unit;
  generate
    for (unit = 0; unit < units_count; unit++) begin : g_match
      logic pc_equal;
      logic cond_a_data;
      logic cond_b_data;
      logic data_cond;
      logic cond_a_res;
      logic res_cond;
      assign pc_equal = fetch.pc == state.code_break_address[unit];
      assign code_hit[unit] = fetch.valid
        && thread_allowed(state.code_break_control[unit], fetch.thread)
        && (state.code_break_control[unit][condition_combine_bit]
            ? !pc_equal : pc_equal);
      assign cond_a_data = memory_op.address >= state.data_watch_first_address[unit];
      assign cond_b_data = memory_op.address <= state.data_watch_second_address[unit];
      assign data_cond = state.data_watch_control[unit][condition_combine_bit]
        ? (cond_a_data || cond_b_data) : (cond_a_data && cond_b_data);
      assign data_hit[unit] = memory_op.valid && memory_op.is_load
        && state.data_watch_control[unit][trigger_on_load_bit]
        && thread_allowed(state.data_watch_control[unit], memory_op.thread)
        && data_cond;
      assign cond_a_res = (resource_op.resource_id & state.resource_watch_mask[unit])
        == state.resource_watch_value[unit];
      assign res_cond = state.resource_watch_control[unit][condition_combine_bit]
        ? !cond_a_res : cond_a_res;
      assign res_hit[unit] = resource_op.valid
        && thread_allowed(state.resource_watch_control[unit], resource_op.thread)
        && res_cond;
    end
  endgenerate

  always_comb begin
    logic [7:0]  a;
    logic [31:0] w;
    logic [2:0]  events;
    logic [1:0]  sub;
    next_state = state;
    a = reg_request.address;
    w = reg_request.write_data;
    sub = a[1:0];
    events = 3'h0;
    next_state.debug_interrupt = 1'b0;
    next_state.read_data = 32'h0000_0000;

    if (reg_request.write) begin
      if (a == idx_event_data) begin
        next_state.debug_event_data = w;
      end
      if (a == idx_stop_mask) begin
        next_state.thread_stop_mask = w[7:0];
      end
      if (a[7:3] == idx_scratch_base[7:3]) begin
        next_state.debugger_scratch_words[a[2:0]] = w;
      end
      if (in_block(a, idx_code_addr_base)) begin
        next_state.code_break_address[sub] = w;
      end
      if (in_block(a, idx_code_ctrl_base)) begin
        next_state.code_break_control[sub] = w & code_ctrl_write_mask;
      end
      if (in_block(a, idx_data_first_base)) begin
        next_state.data_watch_first_address[sub] = w;
      end
      if (in_block(a, idx_data_second_base)) begin
        next_state.data_watch_second_address[sub] = w;
      end
      if (in_block(a, idx_data_ctrl_base)) begin
        next_state.data_watch_control[sub] = w & data_ctrl_write_mask;
      end
      if (in_block(a, idx_res_mask_base)) begin
        next_state.resource_watch_mask[sub] = w;
      end
      if (in_block(a, idx_res_value_base)) begin
        next_state.resource_watch_value[sub] = w;
      end
      if (in_block(a, idx_res_ctrl_base)) begin
        next_state.resource_watch_control[sub] = w & res_ctrl_write_mask;
      end
      if (a == idx_irq_status) begin
        next_state.irq_status = state.irq_status & ~w[2:0];
      end
      if (a == idx_irq_mask) begin
        next_state.irq_mask = w[2:0];
      end
    end else if (scratch_request.write) begin
      next_state.debugger_scratch_words[scratch_request.index] =
        scratch_request.write_data;
    end
    next_state.scratch_read_data =
      next_state.debugger_scratch_words[scratch_request.index];

    if (reg_request.read) begin
      if (a == idx_event_data) begin
        next_state.read_data = state.debug_event_data;
      end else if (a == idx_stop_mask) begin
        next_state.read_data = {24'h00_0000, state.thread_stop_mask};
      end else if (a[7:3] == idx_scratch_base[7:3]) begin
        next_state.read_data = state.debugger_scratch_words[a[2:0]];
      end else if (in_block(a, idx_code_addr_base)) begin
        next_state.read_data = state.code_break_address[sub];
      end else if (in_block(a, idx_code_ctrl_base)) begin
        next_state.read_data = state.code_break_control[sub];
      end else if (in_block(a, idx_data_first_base)) begin
        next_state.read_data = state.data_watch_first_address[sub];
      end else if (in_block(a, idx_data_second_base)) begin
        next_state.read_data = state.data_watch_second_address[sub];
      end else if (in_block(a, idx_data_ctrl_base)) begin
        next_state.read_data = state.data_watch_control[sub];
      end else if (in_block(a, idx_res_mask_base)) begin
        next_state.read_data = state.resource_watch_mask[sub];
      end else if (in_block(a, idx_res_value_base)) begin
        next_state.read_data = state.resource_watch_value[sub];
      end else if (in_block(a, idx_res_ctrl_base)) begin
        next_state.read_data = state.resource_watch_control[sub];
      end else if (a == idx_event_cause) begin
        next_state.read_data = {29'h0000_0000, state.event_cause};
      end else if (a == idx_irq_status) begin
        next_state.read_data = {29'h0000_0000, state.irq_status};
      end else if (a == idx_irq_mask) begin
        next_state.read_data = {29'h0000_0000, state.irq_mask};
      end
    end

    // Event priority: code, then data, then resource
    if (|code_hit) begin
      events[irq_code_pos] = 1'b1;
      next_state.debug_interrupt = 1'b1;
      next_state.debug_thread = fetch.thread;
      next_state.event_cause = cause_code_break;
    end else if (|data_hit) begin
      events[irq_data_pos] = 1'b1;
      next_state.debug_interrupt = 1'b1;
      next_state.debug_thread = memory_op.thread;
      next_state.event_cause = cause_data_watch;
      next_state.debug_event_data = memory_op.address;
    end else if (|res_hit) begin
      events[irq_res_pos] = 1'b1;
      next_state.debug_interrupt = 1'b1;
      next_state.debug_thread = resource_op.thread;
      next_state.event_cause = cause_res_watch;
      next_state.debug_event_data = resource_op.resource_id;
    end
    // Set wins over a clear in the same cycle
    next_state.irq_status = next_state.irq_status | events;
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);

    if (debug_return) begin
      next_state.thread_stopped = next_state.thread_stop_mask;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign read_data         = state.read_data;
  assign scratch_read_data = state.scratch_read_data;
  assign debug_interrupt   = state.debug_interrupt;
  assign debug_thread      = state.debug_thread;
  assign thread_stopped    = state.thread_stopped;
  assign irq               = state.irq;

endmodule // debug_breakpoint_watch_unit

/* debug_breakpoint_watch_unit_assertions.sv */
/*
  Port checker for the debug breakpoint and watchpoint unit.
  Assumes one clock domain; bound to the unit below.
*/
`timescale 1ns/10ps
module debug_watch_checker
  import debug_watch_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst_n,
  input wire fetch_type           fetch,
  input wire memory_op_type       memory_op,
  input wire resource_op_type     resource_op,
  input wire logic                debug_return,
  input wire reg_request_type     reg_request,
  input wire scratch_request_type scratch_request,
  input wire logic [31:0]         read_data,
  input wire logic [31:0]         scratch_read_data,
  input wire logic                debug_interrupt,
  input wire logic [2:0]          debug_thread,
  input wire logic [7:0]          thread_stopped,
  input wire logic                irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_no_cause;
    !$past(fetch.valid) && !($past(memory_op.valid) && $past(memory_op.is_load))
      && !$past(resource_op.valid) |-> !debug_interrupt;
  endproperty
  a_no_cause: assert property (p_no_cause) else $error("interrupt without event");
  property p_data_thread;
    debug_interrupt && !$past(fetch.valid) && !$past(resource_op.valid)
      |-> debug_thread == $past(memory_op.thread);
  endproperty
  a_data_thread: assert property (p_data_thread) else $error("data thread wrong");
  property p_res_thread;
    debug_interrupt && !$past(fetch.valid) && !$past(memory_op.valid)
      |-> debug_thread == $past(resource_op.thread);
  endproperty
  a_res_thread: assert property (p_res_thread) else $error("resource thread wrong");
  property p_stop_hold;
    !debug_return |=> $stable(thread_stopped);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop set moved");
  property p_read_idle;
    !$past(reg_request.read) |-> read_data == 32'h0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");
  property p_scratch;
    scratch_request.write && !reg_request.write
      |=> scratch_read_data == $past(scratch_request.write_data);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch word wrong");
  property p_irq_rise;
    $rose(irq) |-> debug_interrupt || $past(debug_interrupt)
      || $past(reg_request.write) || $past(reg_request.write, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
  property p_irq_fall;
    $fell(irq) |-> $past(reg_request.write) || $past(reg_request.write, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule // debug_watch_checker

bind debug_breakpoint_watch_unit debug_watch_checker checker_inst (
  .clock(clock), .rst_n(rst_n), .fetch(fetch), .memory_op(memory_op),
  .resource_op(resource_op), .debug_return(debug_return), .reg_request(reg_request),
  .scratch_request(scratch_request), .read_data(read_data),
  .scratch_read_data(scratch_read_data), .debug_interrupt(debug_interrupt),
  .debug_thread(debug_thread), .thread_stopped(thread_stopped), .irq(irq)
);

/* pipeline_model.sv */
/*
  Pipeline model: issues one-cycle fetch, memory, resource and return pulses.
  Assumes the caller waits for each issue to finish.
*/
`timescale 1ns/10ps
module pipeline_model
  import debug_watch_pkg::*;
(
  input  wire logic       clock,
  output fetch_type       fetch,
  output memory_op_type   memory_op,
  output resource_op_type resource_op,
  output logic            debug_return
);
  initial begin
    fetch = '0;
    memory_op = '0;
    resource_op = '0;
    debug_return = 1'b0;
  end
  task automatic issue(input int kind, input logic load, input logic [2:0] th,
                       input logic [31:0] v);
    @(posedge clock);
    case (kind)
      0: fetch <= '{1'b1, th, v};
      1: memory_op <= '{1'b1, load, th, v};
      2: resource_op <= '{1'b1, th, v};
      default: debug_return <= 1'b1;
    endcase
    @(posedge clock);
    fetch <= '{1'b0, ~th, ~v};
    memory_op <= '{1'b0, ~load, ~th, ~v};
    resource_op <= '{1'b0, ~th, ~v};
    debug_return <= 1'b0;
  endtask
endmodule // pipeline_model

/* debug_breakpoint_watch_unit_test.sv */
/*
  Register-level test of the debug breakpoint and watchpoint unit.
  Assumes the pipeline model and the port checker beside it.
*/
`timescale 1ns/10ps
module debug_breakpoint_watch_unit_test
  import debug_watch_pkg::*;
  ;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  fetch_type           fetch;
  memory_op_type       memory_op;
  resource_op_type     resource_op;
  logic                debug_return;
  reg_request_type     reg_request = '0;
  scratch_request_type scratch_request = '0;
  logic [31:0]         read_data;
  logic [31:0]         scratch_read_data;
  logic                debug_interrupt;
  logic                irq;
  logic [2:0]          debug_thread;
  logic [7:0]          thread_stopped;
  int                  num_errors = 0;
  int                  checked = 0;
  int                  cycles = 0;

  always #10 clock = ~clock;
  debug_breakpoint_watch_unit DUT (.clock(clock), .rst_n(rst_n), .fetch(fetch),
    .memory_op(memory_op), .resource_op(resource_op), .debug_return(debug_return),
    .reg_request(reg_request), .scratch_request(scratch_request), .read_data(read_data),
    .scratch_read_data(scratch_read_data), .debug_interrupt(debug_interrupt),
    .debug_thread(debug_thread), .thread_stopped(thread_stopped), .irq(irq));
  pipeline_model pipe (.clock(clock), .fetch(fetch), .memory_op(memory_op),
    .resource_op(resource_op), .debug_return(debug_return));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_request <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    reg_request <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_request <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    reg_request <= '0;
    #1 check("read_data", read_data, exp);
  endtask
  task automatic hit(input int k, input logic ld, input logic [2:0] th,
                     input logic [31:0] v, input logic exp);
    pipe.issue(k, ld, th, v);
    #1 check("debug_interrupt", {31'h0, debug_interrupt}, {31'h0, exp});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (int u = 0; u < 4; u++) begin
      rd(idx_code_ctrl_base + u[7:0], 32'h0);
      rd(idx_data_ctrl_base + u[7:0], 32'h0);
      rd(idx_res_ctrl_base + u[7:0], 32'h0);
    end
    wr(idx_code_ctrl_base + 8'h1, 32'hffff_ffff);
    rd(idx_code_ctrl_base + 8'h1, 32'h00ff_0003);
    wr(idx_data_ctrl_base + 8'h3, 32'hffff_ffff);
    rd(idx_data_ctrl_base + 8'h3, 32'h00ff_0007);
    wr(idx_code_ctrl_base + 8'h1, 32'h0);
    wr(idx_data_ctrl_base + 8'h3, 32'h0);
    wr(8'h10, 32'h1234_5678);
    rd(8'h10, 32'h0);
    // Code breakpoint on thread 2
    wr(idx_code_addr_base + 8'h2, 32'h0000_0100);
    wr(idx_code_ctrl_base + 8'h2, 32'h0004_0001);
    hit(0, 1'b0, 3'd3, 32'h100, 1'b0);
    hit(0, 1'b0, 3'd2, 32'h104, 1'b0);
    hit(0, 1'b0, 3'd2, 32'h100, 1'b1);
    check("debug_thread", {29'h0, debug_thread}, 32'h2);
    rd(idx_event_cause, 32'h3);
    wr(idx_code_ctrl_base + 8'h2, 32'h0004_0003);
    hit(0, 1'b0, 3'd2, 32'h100, 1'b0);
    hit(0, 1'b0, 3'd2, 32'h104, 1'b1);
    wr(idx_code_ctrl_base + 8'h2, 32'h0);
    // Data watch on thread 0, loads, both conditions
    wr(idx_data_first_base + 8'h1, 32'h1000);
    wr(idx_data_second_base + 8'h1, 32'h2000);
    wr(idx_irq_mask, 32'h2);
    wr(idx_data_ctrl_base + 8'h1, 32'h0001_0005);
    hit(1, 1'b0, 3'd0, 32'h1800, 1'b0);
    hit(1, 1'b1, 3'd0, 32'h2001, 1'b0);
    hit(1, 1'b1, 3'd0, 32'h2000, 1'b1);
    rd(idx_event_data, 32'h2000);
    rd(idx_event_cause, 32'h4);
    check("irq", {31'h0, irq}, 32'h1);
    wr(idx_irq_status, 32'h2);
    rd(idx_irq_status, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    wr(idx_data_ctrl_base + 8'h1, 32'h0001_0007);
    hit(1, 1'b1, 3'd0, 32'h0fff, 1'b1);
    wr(idx_irq_mask, 32'h0);
    rd(idx_irq_status, 32'h3);
    check("irq", {31'h0, irq}, 32'h0);
    wr(idx_irq_status, 32'h2);
    wr(idx_data_ctrl_base + 8'h1, 32'h0);
    // Resource watch on thread 1
    wr(idx_res_mask_base + 8'h3, 32'hff);
    wr(idx_res_value_base + 8'h3, 32'h12);
    wr(idx_res_ctrl_base + 8'h3, 32'h0002_0001);
    hit(2, 1'b0, 3'd0, 32'hab12, 1'b0);
    hit(2, 1'b0, 3'd1, 32'hab13, 1'b0);
    hit(2, 1'b0, 3'd1, 32'hab12, 1'b1);
    rd(idx_event_data, 32'hab12);
    rd(idx_event_cause, 32'h5);
    wr(idx_res_ctrl_base + 8'h3, 32'h0002_0003);
    hit(2, 1'b0, 3'd1, 32'h12, 1'b0);
    hit(2, 1'b0, 3'd1, 32'h13, 1'b1);
    // Stop set and scratch words
    wr(idx_stop_mask, 32'h5a);
    #1 check("thread_stopped", {24'h0, thread_stopped}, 32'h0);
    pipe.issue(3, 1'b0, 3'd0, 32'h0);
    #1 check("thread_stopped", {24'h0, thread_stopped}, 32'h5a);
    @(posedge clock);
    scratch_request <= '{1'b1, 3'd3, 32'hcafe_0003};
    @(posedge clock);
    scratch_request <= '0;
    #1 check("scratch_read_data", scratch_read_data, 32'hcafe_0003);
    rd(idx_scratch_base + 8'h3, 32'hcafe_0003);
    wr(idx_scratch_base + 8'h5, 32'hbeef_0005);
    scratch_request <= '{1'b0, 3'd5, 32'h0};
    @(posedge clock);
    #1 check("scratch_read_data", scratch_read_data, 32'hbeef_0005);
    test_done();
  end
endmodule // debug_breakpoint_watch_unit_test
